// ---- core/count_clock_if.sv ----
// Count clock request and answer between timer core and source select
`timescale 1ns/1ps
interface count_clock_if;
  logic [1:0] clock_select;
  logic osc_enable;
  logic no_sync;
  logic sleep;
  logic rearm;
  logic tick;

  modport core (
    output clock_select,
    output osc_enable,
    output no_sync,
    output sleep,
    output rearm,
    input tick
  );

  modport src (
    input clock_select,
    input osc_enable,
    input no_sync,
    input sleep,
    input rearm,
    output tick
  );
endinterface

// ---- core/count_source.sv ----
// Count clock selection, input synchronisation and falling-edge arming
`timescale 1ns/1ps
`include "timer_map.svh"
module count_source (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Pins
  input wire logic external_count_pin,
  input wire logic crystal_in_pin,
  // Core side
  count_clock_if.src link
);

  logic raw_level;
  logic sync_a;
  logic sync_b;
  logic prev_level;
  logic [1:0] instr_phase;
  timer_pkg::arm_state_t arm_state;

  logic level;
  logic rising;
  logic falling;
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev_level;
  logic [1:0] next_instr_phase;
  timer_pkg::arm_state_t next_arm_state;

  // Oscillator or pin, then optional two-stage synchroniser
  always_comb begin
    raw_level = link.osc_enable ? crystal_in_pin : external_count_pin;
    next_sync_a = raw_level;
    next_sync_b = sync_a;
    // Bypass of the synchroniser; a mode switch may skip or add one edge
    level = link.no_sync ? raw_level : sync_b;
    next_prev_level = level;
    rising = level & ~prev_level;
    falling = ~level & prev_level;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev_level <= 1'b0;
    end else if (ce) begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev_level <= next_prev_level;
    end
  end

  // Instruction clock phase, stopped in sleep
  always_comb begin
    next_instr_phase = instr_phase;
    if (!link.sleep) begin
      next_instr_phase = instr_phase + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_phase <= `INSTR_PHASE_RESET;
    end else if (ce) begin
      instr_phase <= next_instr_phase;
    end
  end

  // A fall must be seen before the first counted rise
  always_comb begin
    next_arm_state = arm_state;
    unique case (arm_state)
      timer_pkg::ARM_WAIT_FALL: begin
        if (!link.rearm && falling) begin
          next_arm_state = timer_pkg::ARM_READY;
        end
      end
      timer_pkg::ARM_READY: begin
        if (link.rearm) begin
          next_arm_state = timer_pkg::ARM_WAIT_FALL;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arm_state <= timer_pkg::ARM_WAIT_FALL;
    end else if (ce) begin
      arm_state <= next_arm_state;
    end
  end

  // One-cycle count tick of the selected source
  always_comb begin
    link.tick = 1'b0;
    unique case (link.clock_select)
      `CS_SYSTEM: link.tick = ~link.sleep;
      `CS_INSTR: link.tick = ~link.sleep & (instr_phase == `INSTR_PHASE_LAST);
      `CS_EXT: begin
        // Only the unsynchronised path keeps counting in sleep
        link.tick = rising & (arm_state == timer_pkg::ARM_READY) & (link.no_sync | ~link.sleep);
      end
      default: link.tick = 1'b0;
    endcase
  end

endmodule

// ---- core/gated_timer.sv ----
// Gated sixteen-bit timer/counter with prescaler and shared oscillator control
// Function
// - 16-bit up counter, byte writes load directly
// - Off without timer_on; gate_enable makes gated
// - clock_select picks instruction, system or external input
// - One oscillator shared; osc_enable selects it
// - System clock adds four per instruction cycle
// - Instruction clock adds one per cycle
// - External rising edges, synchronised or not
// - Falling edge needed after reset, write, disable
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden; cleared by counter byte writes
// - Oscillator runs on any enable, persists in sleep
// - no_sync bypasses external input synchronisation
// - Asynchronous external counting continues and wakes
// - Sync mode switch may lose/add one
// - Gate level must match polarity to count
// - Byte reads stay valid while counting externally
`timescale 1ns/1ps
`include "timer_map.svh"
module gated_timer #(
  parameter int COUNT_WIDTH = 16,
  parameter int PRESCALE_BITS = 2
) (
  // Clock, reset and freeze
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Timer control
  input wire logic timer_on,
  input wire logic gate_enable,
  input wire logic gate_polarity,
  input wire logic gate_pin,
  input wire logic [1:0] clock_select,
  input wire logic osc_enable,
  input wire logic no_sync,
  input wire logic [PRESCALE_BITS-1:0] prescale_field,
  input wire logic sleep,
  // Count input
  input wire logic external_count_pin,
  // Shared secondary oscillator
  input wire logic [1:0] other_osc_enable,
  input wire logic osc_go,
  input wire logic [1:0] system_clock_select,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  output logic osc_running,
  // Counter byte access
  input wire logic write_high,
  input wire logic write_low,
  input wire logic [7:0] write_data,
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  // Overflow
  input wire logic overflow_int_enable,
  input wire logic clear_overflow,
  output logic overflow_flag,
  output logic overflow_irq,
  output logic wake_request
);

  localparam int PS_CNT_W = (1 << PRESCALE_BITS) - 1;

  // Refuse shapes the byte access and prescale codes cannot serve
  if (COUNT_WIDTH != 16) begin : g_bad_width
    $error("gated_timer: COUNT_WIDTH must be 16");
  end
  if (PRESCALE_BITS != 2) begin : g_bad_prescale
    $error("gated_timer: PRESCALE_BITS must be 2");
  end

  // Terminal prescale count for a divide by two to the power ps
  function automatic logic [PS_CNT_W-1:0] prescale_last(input logic [PRESCALE_BITS-1:0] ps);
    prescale_last = PS_CNT_W'((1 << ps) - 1);
  endfunction

  // Prescale count has reached the end of its division
  function automatic logic prescale_due(
    input logic [PS_CNT_W-1:0] value,
    input logic [PRESCALE_BITS-1:0] ps
  );
    prescale_due = (value >= prescale_last(ps));
  endfunction

  // Count enable from the on bit and the gate level
  function automatic logic gate_open(
    input logic enabled,
    input logic gated,
    input logic level,
    input logic polarity
  );
    gate_open = 1'b0;
    if (enabled) begin
      if (!gated) begin
        gate_open = 1'b1;
      end else begin
        gate_open = (level == polarity);
      end
    end
  endfunction

  // Counter value after a write to either or both bytes
  function automatic logic [COUNT_WIDTH-1:0] load_bytes(
    input logic [COUNT_WIDTH-1:0] value,
    input logic take_high,
    input logic take_low,
    input logic [7:0] data
  );
    load_bytes = value;
    if (take_high) begin
      load_bytes[`HIGH_MSB:`HIGH_LSB] = data;
    end
    if (take_low) begin
      load_bytes[`LOW_MSB:`LOW_LSB] = data;
    end
  endfunction

  // Last count before the counter wraps to zero
  function automatic logic at_wrap(input logic [COUNT_WIDTH-1:0] value);
    at_wrap = (value == `COUNT_WRAP);
  endfunction

  // High and low bytes of a counter value
  function automatic logic [7:0] high_byte(input logic [COUNT_WIDTH-1:0] value);
    high_byte = value[`HIGH_MSB:`HIGH_LSB];
  endfunction

  function automatic logic [7:0] low_byte(input logic [COUNT_WIDTH-1:0] value);
    low_byte = value[`LOW_MSB:`LOW_LSB];
  endfunction

  // Writes and a disabled timer demand a fresh falling edge
  function automatic logic rearm_needed(input logic written, input logic enabled);
    rearm_needed = written | ~enabled;
  endfunction

  // Secondary oscillator demand from every enable source
  function automatic logic osc_demand(
    input logic own_enable,
    input logic [1:0] others,
    input logic go,
    input logic [1:0] sys_select
  );
    osc_demand = own_enable | (|others) | go | (sys_select == `SCS_SECONDARY);
  endfunction

  // Source selection and arming
  count_clock_if link ();

  count_source u_source (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .external_count_pin(external_count_pin),
    .crystal_in_pin(crystal_in_pin),
    .link(link)
  );

  logic count_enable;
  logic any_write;
  logic advance;
  logic wrap;

  logic [COUNT_WIDTH-1:0] count;
  logic [PS_CNT_W-1:0] prescale_count;
  logic [COUNT_WIDTH-1:0] next_count;
  logic [PS_CNT_W-1:0] next_prescale_count;

  logic next_overflow_flag;
  logic next_overflow_irq;
  logic next_wake_request;
  logic next_osc_running;
  logic next_crystal_out_pin;

  // Requests to the source selector
  always_comb begin
    link.clock_select = clock_select;
    link.osc_enable = osc_enable;
    link.no_sync = no_sync;
    link.sleep = sleep;
    // Writes and disable demand a fresh falling edge
    link.rearm = rearm_needed(any_write, timer_on);
  end

  // Enable and gate decode
  always_comb begin
    any_write = write_high | write_low;
    count_enable = gate_open(timer_on, gate_enable, gate_pin, gate_polarity);
  end

  // Prescaler; a byte write restarts the division
  always_comb begin
    next_prescale_count = prescale_count;
    advance = 1'b0;
    if (any_write) begin
      next_prescale_count = `PRESCALE_RESET;
    end else if (count_enable && link.tick) begin
      if (prescale_due(prescale_count, prescale_field)) begin
        next_prescale_count = `PRESCALE_RESET;
        advance = 1'b1;
      end else begin
        next_prescale_count = prescale_count + `PRESCALE_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale_count <= `PRESCALE_RESET;
    end else if (ce) begin
      prescale_count <= next_prescale_count;
    end
  end

  // Counter; a write wins over a tick in the same cycle
  always_comb begin
    next_count = count;
    wrap = 1'b0;
    if (any_write) begin
      next_count = load_bytes(count, write_high, write_low, write_data);
    end else if (advance) begin
      wrap = at_wrap(count);
      next_count = count + `COUNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= `COUNT_RESET;
    end else if (ce) begin
      count <= next_count;
    end
  end

  // Bytes come from the single-domain counter, so reads never tear a byte
  assign count_high_byte = high_byte(count);
  assign count_low_byte = low_byte(count);

  // Overflow flag; a wrap beats a clear
  always_comb begin
    next_overflow_flag = overflow_flag;
    if (clear_overflow) begin
      next_overflow_flag = 1'b0;
    end
    if (wrap) begin
      next_overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (ce) begin
      overflow_flag <= next_overflow_flag;
    end
  end

  // Request and wake follow the flag at the same edge
  always_comb begin
    next_overflow_irq = next_overflow_flag & overflow_int_enable;
    next_wake_request = next_overflow_flag & overflow_int_enable & sleep;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_irq <= 1'b0;
      wake_request <= 1'b0;
    end else if (ce) begin
      overflow_irq <= next_overflow_irq;
      wake_request <= next_wake_request;
    end
  end

  // Shared oscillator run; sleep does not stop it
  always_comb begin
    next_osc_running = osc_demand(osc_enable, other_osc_enable, osc_go, system_clock_select);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_running <= 1'b0;
    end else if (ce) begin
      osc_running <= next_osc_running;
    end
  end

  // Amplifier drive inverts the crystal input while running
  always_comb begin
    next_crystal_out_pin = next_osc_running & ~crystal_in_pin;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crystal_out_pin <= 1'b0;
    end else if (ce) begin
      crystal_out_pin <= next_crystal_out_pin;
    end
  end

endmodule

// ---- core/timer_map.svh ----
// Offsets, encodings, reset values and counts of the gated timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Clock source codes of the clock_select field
`define CS_INSTR 2'h0
`define CS_SYSTEM 2'h1
`define CS_EXT 2'h2

// System clock select code that runs the secondary oscillator
`define SCS_SECONDARY 2'h1

// Instruction clock is the system clock divided by four
`define INSTR_PHASE_LAST 2'h3
`define INSTR_PHASE_RESET 2'h0

// Counter and prescaler
`define COUNT_RESET 16'h0000
`define COUNT_WRAP 16'hffff
`define COUNT_ONE 16'h0001
`define PRESCALE_RESET 3'h0
`define PRESCALE_ONE 3'h1

// Byte split of the counter
`define HIGH_MSB 15
`define HIGH_LSB 8
`define LOW_MSB 7
`define LOW_LSB 0

`endif

// ---- core/timer_pkg.sv ----
// Types shared by the gated timer modules
package timer_pkg;

  // Falling-edge arming of the external count input
  typedef enum logic [0:0] {
    ARM_WAIT_FALL = 1'b0,
    ARM_READY = 1'b1
  } arm_state_t;

endpackage

// ---- testbench/pulse_src.sv ----
// Burst pulse source for the count pin or the crystal input
`timescale 1ns/1ps
module pulse_src (
  // Clock
  input wire logic sys_clk,
  // Control
  input wire logic go,
  // Pin
  output logic pin
);
  int ph = 0;
  // Three cycles low then three high; rests low between bursts
  always @(posedge sys_clk) begin
    ph <= go ? (ph + 1) % 6 : 0;
    pin <= go && ph >= 3;
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the gated timer
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'h0, rst = 1'h1, ce = 1'h1, timer_on = 1'h0, gate_enable = 1'h0, gate_polarity = 1'h0;
  logic gate_pin = 1'h0, osc_enable = 1'h0, no_sync = 1'h0, sleep = 1'h0, osc_go = 1'h0, write_high = 1'h0;
  logic write_low = 1'h0, clear_overflow = 1'h0, overflow_int_enable = 1'h0, go_ext = 1'h0, go_xtal = 1'h0;
  logic external_count_pin, crystal_in_pin, crystal_out_pin, osc_running, overflow_flag, overflow_irq;
  logic wake_request, osc_exp;
  logic [1:0] clock_select = 2'h0, prescale_field = 2'h0, other_osc_enable = 2'h0, system_clock_select = 2'h0;
  logic [7:0] write_data = 8'h00, count_high_byte, count_low_byte;
  logic [31:0] seed = 32'h6fc3ee60, r;
  int fail_count = 0, n_tests = 0, cyc = 0, acc, n, st;

  always #25 sys_clk = ~sys_clk;

  pulse_src ext_u (.sys_clk, .go(go_ext), .pin(external_count_pin));
  pulse_src xtal_u (.sys_clk, .go(go_xtal), .pin(crystal_in_pin));
  gated_timer dut_u (.sys_clk, .rst, .ce, .timer_on, .gate_enable, .gate_polarity, .gate_pin, .clock_select,
    .osc_enable, .no_sync, .prescale_field, .sleep, .external_count_pin, .other_osc_enable, .osc_go,
    .system_clock_select, .crystal_in_pin, .crystal_out_pin, .osc_running, .write_high, .write_low,
    .write_data, .count_high_byte, .count_low_byte, .overflow_int_enable, .clear_overflow,
    .overflow_flag, .overflow_irq, .wake_request);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, s);
    end
  endtask

  // Both bytes written while stopped, so the prescaler restarts from zero
  task automatic load(input logic [15:0] v);
    @(posedge sys_clk);
    timer_on <= 1'h0;
    write_high <= 1'h1;
    write_data <= v[15:8];
    clear_overflow <= 1'h1;
    @(posedge sys_clk);
    write_high <= 1'h0;
    write_low <= 1'h1;
    write_data <= v[7:0];
    @(posedge sys_clk);
    write_low <= 1'h0;
    clear_overflow <= 1'h0;
  endtask

  task automatic fin(input int s, input int inc);
    int t = s + inc;
    logic f = t > 32'h0000ffff;
    @(posedge sys_clk);
    chk16("count", t[15:0], {count_high_byte, count_low_byte});
    chk1("flag", f, overflow_flag);
    chk1("irq", f & overflow_int_enable, overflow_irq);
    chk1("wake", f & overflow_int_enable & sleep, wake_request);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    chk16("reset count", 16'h0000, {count_high_byte, count_low_byte});
    chk1("reset flag", 1'h0, overflow_flag);
    rst <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      st = {8'hff, r[7:0]};
      clock_select <= {1'h0, i[0]};
      prescale_field <= i[2:1];
      gate_enable <= i[3] & i[0];
      gate_polarity <= r[8];
      overflow_int_enable <= r[9];
      n = 8 * (r[12:10] + 1);
      load(st[15:0]);
      acc = 0;
      for (int k = 0; k <= n; k++) begin
        @(posedge sys_clk);
        if (k > 0 && (!gate_enable || gate_pin === gate_polarity)) acc++;
        r = rnd();
        gate_pin <= r[0];
        timer_on <= (k < n);
      end
      fin(st, (i[0] ? acc : n / 4) >> i[2:1]);
    end
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      st = {15'h7fff, r[0]};
      clock_select <= 2'h2;
      osc_enable <= i[0];
      no_sync <= i[1];
      sleep <= i[2];
      prescale_field <= {1'h0, i[3]};
      gate_enable <= 1'h0;
      overflow_int_enable <= 1'h1;
      other_osc_enable <= r[3:2];
      osc_go <= r[4];
      system_clock_select <= r[6:5];
      n = r[8:7] + 2;
      load(st[15:0]);
      repeat (8) @(posedge sys_clk);
      timer_on <= 1'h1;
      @(posedge sys_clk);
      go_ext <= !i[0];
      go_xtal <= i[0];
      osc_exp = i[0] || r[4] || r[3:2] != 2'h0 || r[6:5] == 2'h1;
      repeat (6) @(posedge sys_clk);
      chk1("amp high", osc_exp && !i[0], crystal_out_pin);
      repeat (6 * n - 6) @(posedge sys_clk);
      go_ext <= 1'h0;
      go_xtal <= 1'h0;
      repeat (6) @(posedge sys_clk);
      timer_on <= 1'h0;
      @(posedge sys_clk);
      chk1("osc", osc_exp, osc_running);
      chk1("amp low", osc_exp, crystal_out_pin);
      fin(st, (i[2] && !i[1]) ? 0 : (n - 1) >> i[3]);
    end
    // Clock enable low must freeze a write and the count
    clock_select <= 2'h1;
    sleep <= 1'h0;
    prescale_field <= 2'h0;
    load(16'h1234);
    ce <= 1'h0;
    timer_on <= 1'h1;
    repeat (4) @(posedge sys_clk);
    write_low <= 1'h1;
    write_data <= 8'hff;
    @(posedge sys_clk);
    write_low <= 1'h0;
    timer_on <= 1'h0;
    @(posedge sys_clk);
    ce <= 1'h1;
    fin(16'h1234, 0);
    give_verdict();
  end
endmodule

// ---- testbench/timer_chk.sv ----
// Port-level assertions of the gated timer
`timescale 1ns/1ps
module timer_chk #(
  parameter int COUNT_WIDTH = 16,
  parameter int PRESCALE_BITS = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Controls
  input wire logic timer_on,
  input wire logic gate_enable,
  input wire logic gate_polarity,
  input wire logic gate_pin,
  input wire logic [1:0] clock_select,
  input wire logic [PRESCALE_BITS-1:0] prescale_field,
  input wire logic sleep,
  input wire logic osc_enable,
  input wire logic [1:0] other_osc_enable,
  input wire logic osc_go,
  input wire logic [1:0] system_clock_select,
  input wire logic write_high,
  input wire logic write_low,
  input wire logic [7:0] write_data,
  input wire logic overflow_int_enable,
  // Results
  input wire logic osc_running,
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] count_low_byte,
  input wire logic overflow_flag,
  input wire logic overflow_irq,
  input wire logic wake_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic [15:0] cnt = {count_high_byte, count_low_byte};
  wire logic idle = ce && !write_high && !write_low;
  low_load_a: assert property (ce && write_low |=> count_low_byte == $past(write_data))
    else $error("low byte load");
  off_hold_a: assert property (idle && !timer_on |=> $stable(cnt)) else $error("count while off");
  gate_hold_a: assert property (idle && gate_enable && gate_pin != gate_polarity |=> $stable(cnt))
    else $error("count while gated");
  sys_step_a: assert property (idle && timer_on && !gate_enable && !sleep && clock_select == 2'h1
    && $past(clock_select) == 2'h1 && prescale_field == 2'h0 && cnt != 16'hffff
    |=> cnt == $past(cnt) + 16'h0001) else $error("system clock step");
  wrap_zero_a: assert property ($rose(overflow_flag) |-> cnt == 16'h0000) else $error("flag off wrap");
  irq_flag_a: assert property (overflow_irq |-> overflow_flag && $past(overflow_int_enable))
    else $error("irq without flag");
  wake_sleep_a: assert property (wake_request |-> overflow_irq && $past(sleep))
    else $error("wake outside sleep");
  osc_on_a: assert property (ce && (osc_enable || other_osc_enable != 2'h0 || osc_go
    || system_clock_select == 2'h1) |=> osc_running) else $error("oscillator idle");
  wrap_c: cover property ($rose(overflow_flag));
  wake_c: cover property ($rose(wake_request));
  gate_c: cover property (timer_on && gate_enable && gate_pin != gate_polarity);
endmodule
bind gated_timer timer_chk #(.COUNT_WIDTH(COUNT_WIDTH), .PRESCALE_BITS(PRESCALE_BITS)) chk_u (
  .sys_clk, .rst, .ce, .timer_on, .gate_enable, .gate_polarity, .gate_pin, .clock_select, .prescale_field,
  .sleep, .osc_enable, .other_osc_enable, .osc_go, .system_clock_select, .write_high, .write_low, .write_data,
  .overflow_int_enable, .osc_running, .count_high_byte, .count_low_byte, .overflow_flag, .overflow_irq,
  .wake_request);
